// ===== verilog/ram_io_timer.sv
// RAM, dual I/O port and interval timer peripheral: decode, registers and interrupt logic
`timescale 1ns/1ps
module ram_io_timer
    import ram_io_timer_pkg::*;
(
    input  wire logic                                clock,
    input  wire logic                                rstn,
    input  wire ram_io_timer_pkg::bus_req_t           bus_req,
    output logic       [ram_io_timer_pkg::DATA_W-1:0] data_out,
    output logic                                     data_oe_n,
    input  wire logic  [ram_io_timer_pkg::DATA_W-1:0] port_a_lines_in,
    output logic       [ram_io_timer_pkg::DATA_W-1:0] port_a_lines_out,
    output logic       [ram_io_timer_pkg::DATA_W-1:0] port_a_lines_oe_n,
    input  wire logic  [ram_io_timer_pkg::DATA_W-1:0] port_b_lines_in,
    output logic       [ram_io_timer_pkg::DATA_W-1:0] port_b_lines_out,
    output logic       [ram_io_timer_pkg::DATA_W-1:0] port_b_lines_oe_n,
    output logic                                     irq_out,
    output logic                                     irq_oe_n
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] port_a_output_q, port_a_output_d;
    logic [DATA_W-1:0] port_a_direction_q, port_a_direction_d;
    logic [DATA_W-1:0] port_b_output_q, port_b_output_d;
    logic [DATA_W-1:0] port_b_direction_q, port_b_direction_d;
    logic [DATA_W-1:0] port_a_oe_n_q, port_a_oe_n_d;
    logic [DATA_W-1:0] port_b_oe_n_q, port_b_oe_n_d;
    logic              tmr_irq_en_q, tmr_irq_en_d;
    logic              edge_irq_en_q, edge_irq_en_d;
    logic              edge_pos_q, edge_pos_d;
    logic              tmr_flag_q, tmr_flag_d;
    logic              edge_flag_q, edge_flag_d;
    logic              sense_prev_q, sense_prev_d;
    logic [DATA_W-1:0] data_out_q, data_out_d;
    logic              data_oe_n_q, data_oe_n_d;
    logic              irq_oe_n_q, irq_oe_n_d;
    logic              irq_out_q;
    logic [DATA_W-1:0] ram_q [RAM_WORDS];

    logic [DATA_W-1:0] port_a_level;
    logic [DATA_W-1:0] port_b_level;
    logic [DATA_W-1:0] tmr_count;
    logic              tmr_timeout;

    logic              chip_on;
    logic              ram_sel;
    logic              io_sel;
    logic              rd;
    logic              wr;
    logic              port_acc;
    logic              tmr_acc;
    logic              count_wr;
    logic              count_rd;
    logic              flag_rd;
    logic              edge_wr;
    logic              count_access;
    logic              ram_wr;
    logic              edge_sense_line;
    logic              edge_hit;
    logic [1:0]        port_sel;
    logic [DATA_W-1:0] flag_word;
    logic [DATA_W-1:0] port_b_read;

    // ------------------------------------------------------------------
    // Pin synchronisers and interval timer
    // ------------------------------------------------------------------
    pin_sync #(.W(DATA_W)) u_sync_a
    (
        .clock (clock),
        .rstn  (rstn),
        .pin   (port_a_lines_in),
        .level (port_a_level)
    );

    pin_sync #(.W(DATA_W)) u_sync_b
    (
        .clock (clock),
        .rstn  (rstn),
        .pin   (port_b_lines_in),
        .level (port_b_level)
    );

    interval_timer u_timer
    (
        .clock      (clock),
        .rstn       (rstn),
        .load       (count_wr),
        .load_value (bus_req.wdata),
        .prescale   (bus_req.addr[1:0]),
        .count      (tmr_count),
        .timeout    (tmr_timeout)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Every clock edge with the chip selected counts as one bus access
    always_comb
    begin
        chip_on  = bus_req.chip_select_high && !bus_req.chip_select_low_n;
        ram_sel  = chip_on && !bus_req.ram_io_select_n;
        io_sel   = chip_on && bus_req.ram_io_select_n;
        rd       = bus_req.read_not_write;
        wr       = !bus_req.read_not_write;
        port_sel = bus_req.addr[1:0];
        port_acc = 1'b0;
        tmr_acc  = 1'b0;
        if (io_sel && bus_req.addr[ABIT_SEL_TIMER])
        begin
            tmr_acc = 1'b1;
        end
        else if (io_sel)
        begin
            port_acc = 1'b1;
        end
        count_wr = tmr_acc && wr && bus_req.addr[ABIT_TMR_WRITE];
        edge_wr  = tmr_acc && wr && !bus_req.addr[ABIT_TMR_WRITE];
        count_rd = tmr_acc && rd && !bus_req.addr[ABIT_FLAG_RD];
        flag_rd  = tmr_acc && rd && bus_req.addr[ABIT_FLAG_RD];
        count_access = count_wr || count_rd;
        ram_wr   = ram_sel && wr;
    end

    // ------------------------------------------------------------------
    // Port and control registers
    // ------------------------------------------------------------------
    // Port writes by A1:A0; pin drivers follow the direction bits
    always_comb
    begin
        port_a_output_d    = port_a_output_q;
        port_a_direction_d = port_a_direction_q;
        port_b_output_d    = port_b_output_q;
        port_b_direction_d = port_b_direction_q;
        if (port_acc && wr && port_sel == SEL_PORT_A_OUTPUT)
        begin
            port_a_output_d = bus_req.wdata;
        end
        else if (port_acc && wr && port_sel == SEL_PORT_A_DIR)
        begin
            port_a_direction_d = bus_req.wdata;
        end
        else if (port_acc && wr && port_sel == SEL_PORT_B_OUTPUT)
        begin
            port_b_output_d = bus_req.wdata;
        end
        else if (port_acc && wr && port_sel == SEL_PORT_B_DIR)
        begin
            port_b_direction_d = bus_req.wdata;
        end
        port_a_oe_n_d = ~port_a_direction_d;
        port_b_oe_n_d = ~port_b_direction_d;
    end

    // Timer enable follows A3 on any count access; edge control ignores data
    always_comb
    begin
        tmr_irq_en_d  = tmr_irq_en_q;
        edge_irq_en_d = edge_irq_en_q;
        edge_pos_d    = edge_pos_q;
        if (count_access)
        begin
            tmr_irq_en_d = bus_req.addr[ABIT_TMR_IRQ];
        end
        if (edge_wr)
        begin
            edge_irq_en_d = bus_req.addr[ABIT_EDGE_EN];
            edge_pos_d    = bus_req.addr[ABIT_EDGE_POS];
        end
    end

    // ------------------------------------------------------------------
    // Flags and interrupt
    // ------------------------------------------------------------------
    // Sets beat clears, so an event in the clearing cycle is never lost
    always_comb
    begin
        edge_sense_line = port_a_level[DATA_W-1];
        sense_prev_d    = edge_sense_line;
        if (edge_pos_q)
        begin
            edge_hit = edge_sense_line && !sense_prev_q;
        end
        else
        begin
            edge_hit = !edge_sense_line && sense_prev_q;
        end
        edge_flag_d = edge_hit || (edge_flag_q && !flag_rd);
        tmr_flag_d  = tmr_timeout || (tmr_flag_q && !count_access);
        irq_oe_n_d  = !((tmr_flag_d && tmr_irq_en_d) ||
                        (edge_flag_d && edge_irq_en_d));
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Answer is registered: data stands on the bus in the cycle after the request
    always_comb
    begin
        flag_word                 = '0;
        flag_word[FLAG_TIMER_BIT] = tmr_flag_q;
        flag_word[FLAG_EDGE_BIT]  = edge_flag_q;
        // Port B reads its own register on output lines, so heavy loads cannot corrupt it
        port_b_read = (port_b_output_q & port_b_direction_q) |
                      (port_b_level & ~port_b_direction_q);
        data_out_d  = data_out_q;
        data_oe_n_d = 1'b1;
        if (ram_sel && rd)
        begin
            data_out_d  = ram_q[bus_req.addr];
            data_oe_n_d = 1'b0;
        end
        else if (port_acc && rd)
        begin
            data_oe_n_d = 1'b0;
            case (port_sel)
                SEL_PORT_A_OUTPUT: data_out_d = port_a_level;
                SEL_PORT_A_DIR:    data_out_d = port_a_direction_q;
                SEL_PORT_B_OUTPUT: data_out_d = port_b_read;
                default:           data_out_d = port_b_direction_q;
            endcase
        end
        else if (count_rd)
        begin
            data_out_d  = tmr_count;
            data_oe_n_d = 1'b0;
        end
        else if (flag_rd)
        begin
            data_out_d  = flag_word;
            data_oe_n_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // All state commits at the clock edge that ends the access
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            port_a_output_q    <= PORT_RST;
            port_a_direction_q <= PORT_RST;
            port_b_output_q    <= PORT_RST;
            port_b_direction_q <= PORT_RST;
            port_a_oe_n_q      <= ~PORT_RST;
            port_b_oe_n_q      <= ~PORT_RST;
            tmr_irq_en_q       <= 1'b0;
            edge_irq_en_q      <= 1'b0;
            edge_pos_q         <= 1'b0;
            tmr_flag_q         <= 1'b0;
            edge_flag_q        <= 1'b0;
            sense_prev_q       <= 1'b0;
            data_out_q         <= '0;
            data_oe_n_q        <= 1'b1;
            irq_oe_n_q         <= 1'b1;
            irq_out_q          <= 1'b0;
        end
        else
        begin
            port_a_output_q    <= port_a_output_d;
            port_a_direction_q <= port_a_direction_d;
            port_b_output_q    <= port_b_output_d;
            port_b_direction_q <= port_b_direction_d;
            port_a_oe_n_q      <= port_a_oe_n_d;
            port_b_oe_n_q      <= port_b_oe_n_d;
            tmr_irq_en_q       <= tmr_irq_en_d;
            edge_irq_en_q      <= edge_irq_en_d;
            edge_pos_q         <= edge_pos_d;
            tmr_flag_q         <= tmr_flag_d;
            edge_flag_q        <= edge_flag_d;
            sense_prev_q       <= sense_prev_d;
            data_out_q         <= data_out_d;
            data_oe_n_q        <= data_oe_n_d;
            irq_oe_n_q         <= irq_oe_n_d;
            irq_out_q          <= 1'b0;                                    // Open drain only ever sinks
        end
    end

    // RAM array has no reset; contents are undefined until written
    always_ff @(posedge clock)
    begin
        if (ram_wr)
        begin
            ram_q[bus_req.addr] <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign data_out          = data_out_q;
    assign data_oe_n         = data_oe_n_q;
    assign port_a_lines_out  = port_a_output_q;
    assign port_a_lines_oe_n = port_a_oe_n_q;
    assign port_b_lines_out  = port_b_output_q;
    assign port_b_lines_oe_n = port_b_oe_n_q;
    assign irq_out           = irq_out_q;
    assign irq_oe_n          = irq_oe_n_q;
endmodule

// ===== verilog/ram_io_timer_pkg.sv
// Shared constants, field positions and carrier types for the RAM, I/O and timer block
package ram_io_timer_pkg;

    // ------------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------------
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 7;
    localparam int RAM_WORDS = 128;
    localparam int PRE_W     = 10;

    // ------------------------------------------------------------------
    // Address bit positions used by the I/O and timer decode
    // ------------------------------------------------------------------
    localparam int ABIT_SEL_TIMER = 2;  // High: timer and flags, low: ports
    localparam int ABIT_TMR_IRQ   = 3;  // Timer interrupt enable on count access
    localparam int ABIT_TMR_WRITE = 4;  // High: count write, low: edge control
    localparam int ABIT_EDGE_EN   = 1;  // Edge control: interrupt enable
    localparam int ABIT_EDGE_POS  = 0;  // Edge control: 1 positive, 0 negative
    localparam int ABIT_FLAG_RD   = 0;  // Timer area read: 1 flags, 0 count

    // ------------------------------------------------------------------
    // Port register select on A1:A0 and prescale codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_PORT_A_OUTPUT = 2'h0;
    localparam logic [1:0] SEL_PORT_A_DIR    = 2'h1;
    localparam logic [1:0] SEL_PORT_B_OUTPUT = 2'h2;
    localparam logic [1:0] SEL_PORT_B_DIR    = 2'h3;

    localparam logic [1:0] DIV_1    = 2'h0;
    localparam logic [1:0] DIV_8    = 2'h1;
    localparam logic [1:0] DIV_64   = 2'h2;
    localparam logic [1:0] DIV_1024 = 2'h3;

    // Prescaler reload values: the divide ratio minus one
    localparam logic [PRE_W-1:0] RELOAD_1    = 10'h000;
    localparam logic [PRE_W-1:0] RELOAD_8    = 10'h007;
    localparam logic [PRE_W-1:0] RELOAD_64   = 10'h03f;
    localparam logic [PRE_W-1:0] RELOAD_1024 = 10'h3ff;

    // ------------------------------------------------------------------
    // Flag register layout and reset values
    // ------------------------------------------------------------------
    localparam int FLAG_TIMER_BIT = 7;
    localparam int FLAG_EDGE_BIT  = 6;

    localparam logic [DATA_W-1:0] PORT_RST  = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_RST = 8'hff;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {tmr_counting, tmr_expired} tmr_phase_t;

    typedef struct packed {
        logic              chip_select_high;
        logic              chip_select_low_n;
        logic              ram_io_select_n;
        logic              read_not_write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

endpackage

// ===== verilog/pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync
#(
    parameter int W = 8
)
(
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;
    logic [W-1:0] agree;

    // Per bit, keep the old level while the last two stages still disagree
    always_comb
    begin
        agree   = ~(s2_q ^ s3_q);
        level_d = (s3_q & agree) | (level_q & ~agree);
    end

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end
        else
        begin
            s1_q    <= pin;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule

// ===== verilog/interval_timer.sv
// Interval timer: prescaled 8-bit down counter that runs on at full rate after timeout
`timescale 1ns/1ps
module interval_timer
    import ram_io_timer_pkg::*;
(
    input  wire logic                               clock,
    input  wire logic                               rstn,
    input  wire logic                               load,
    input  wire logic [ram_io_timer_pkg::DATA_W-1:0] load_value,
    input  wire logic [1:0]                         prescale,
    output logic      [ram_io_timer_pkg::DATA_W-1:0] count,
    output logic                                    timeout
);
    logic [DATA_W-1:0] count_q, count_d;
    logic [PRE_W-1:0]  pre_q, pre_d;
    logic [PRE_W-1:0]  reload_q, reload_d;
    tmr_phase_t        phase_q, phase_d;
    logic              timeout_q, timeout_d;
    logic              tick;
    logic [PRE_W-1:0]  sel_reload;

    // Countdown; a write restarts prescaling, after expiry every clock is a tick
    always_comb
    begin
        count_d   = count_q;
        pre_d     = pre_q;
        reload_d  = reload_q;
        phase_d   = phase_q;
        timeout_d = 1'b0;
        case (prescale)
            DIV_1:   sel_reload = RELOAD_1;
            DIV_8:   sel_reload = RELOAD_8;
            DIV_64:  sel_reload = RELOAD_64;
            default: sel_reload = RELOAD_1024;
        endcase
        tick = (phase_q == tmr_expired) || (pre_q == '0);
        if (load)
        begin
            count_d  = load_value;
            reload_d = sel_reload;
            pre_d    = sel_reload;
            phase_d  = tmr_counting;
        end
        else if (tick)
        begin
            count_d = DATA_W'(count_q - 8'h01);
            case (phase_q)
                tmr_counting:
                begin
                    pre_d = reload_q;
                    if (count_q == '0)
                    begin
                        timeout_d = 1'b1;               // Passing zero ends the interval
                        phase_d   = tmr_expired;
                    end
                end
                default: pre_d = pre_q;
            endcase
        end
        else
        begin
            pre_d = PRE_W'(pre_q - 10'h001);
        end
    end

    // Reset parks the timer expired, so no timeout fires before the first write
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            count_q   <= COUNT_RST;
            pre_q     <= RELOAD_1;
            reload_q  <= RELOAD_1;
            phase_q   <= tmr_expired;
            timeout_q <= 1'b0;
        end
        else
        begin
            count_q   <= count_d;
            pre_q     <= pre_d;
            reload_q  <= reload_d;
            phase_q   <= phase_d;
            timeout_q <= timeout_d;
        end
    end

    assign count   = count_q;
    assign timeout = timeout_q;
endmodule

// ===== testbench/ram_io_timer_properties.sv
// Port-level assertions for the RAM, I/O and timer block
`timescale 1ns/1ps
module ram_io_timer_properties
    import ram_io_timer_pkg::*;
(
    input wire logic                        clock,
    input wire logic                        rstn,
    input wire ram_io_timer_pkg::bus_req_t  bus_req,
    input wire logic [7:0]                  data_out,
    input wire logic                        data_oe_n,
    input wire logic [7:0]                  port_a_lines_out,
    input wire logic [7:0]                  port_a_lines_oe_n,
    input wire logic [7:0]                  port_b_lines_oe_n,
    input wire logic                        irq_out
);
    // Decoded select terms
    logic sel;
    logic io;
    logic wr_io;
    assign sel   = bus_req.chip_select_high & ~bus_req.chip_select_low_n;
    assign io    = sel & bus_req.ram_io_select_n;
    assign wr_io = io & ~bus_req.read_not_write & ~bus_req.addr[2];
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_rd; sel && bus_req.read_not_write |=> !data_oe_n; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_idle; !(sel && bus_req.read_not_write) |=> data_oe_n; endproperty
    a_idle: assert property (p_idle) else $error("data driven outside read");
    property p_sink; irq_out == 1'h0; endproperty
    a_sink: assert property (p_sink) else $error("interrupt pin drives high");
    property p_adir; wr_io && bus_req.addr[1:0] == 2'h1 |=> port_a_lines_oe_n == ~$past(bus_req.wdata); endproperty
    a_adir: assert property (p_adir) else $error("port A direction wrong");
    property p_bdir; wr_io && bus_req.addr[1:0] == 2'h3 |=> port_b_lines_oe_n == ~$past(bus_req.wdata); endproperty
    a_bdir: assert property (p_bdir) else $error("port B direction wrong");
    property p_aout; wr_io && bus_req.addr[1:0] == 2'h0 |=> port_a_lines_out == $past(bus_req.wdata); endproperty
    a_aout: assert property (p_aout) else $error("port A output wrong");
    property p_flags; io && bus_req.read_not_write && bus_req.addr[2] && bus_req.addr[0] |=> data_out[5:0] == 6'h00;
    endproperty
    a_flags: assert property (p_flags) else $error("flag register spare bits set");
    property p_ram; sel && !bus_req.ram_io_select_n |=> $stable(port_a_lines_out) && $stable(port_b_lines_oe_n);
    endproperty
    a_ram: assert property (p_ram) else $error("RAM access hit a port");
endmodule
bind ram_io_timer ram_io_timer_properties chk_u (.clock(clock), .rstn(rstn), .bus_req(bus_req),
    .data_out(data_out), .data_oe_n(data_oe_n), .port_a_lines_out(port_a_lines_out),
    .port_a_lines_oe_n(port_a_lines_oe_n), .port_b_lines_oe_n(port_b_lines_oe_n), .irq_out(irq_out));

// ===== testbench/bus_master.sv
// Processor bus model issuing single-byte accesses
`timescale 1ns/1ps
module bus_master
    import ram_io_timer_pkg::*;
(
    input  wire logic                 clock,
    output ram_io_timer_pkg::bus_req_t bus_req
);
    initial bus_req = '0;
    // Request held across one rising edge; released lines show the inverse, bar chip_select_high, which stays 1
    task automatic xfer(input logic rnw, input logic rs, input logic [6:0] a, input logic [7:0] wd);
        @(negedge clock);
        bus_req <= '{1'h1, 1'h0, rs, rnw, a, wd};
        @(negedge clock);
        bus_req <= '{1'h1, 1'h1, ~rs, ~rnw, ~a, ~wd};
    endtask
endmodule

// ===== testbench/test_ram_io_timer.sv
// Self-checking bench for the RAM, I/O and timer block
`timescale 1ns/1ps
module test_ram_io_timer;
    import ram_io_timer_pkg::*;
    logic       clock = 1'h0;
    logic       rstn  = 1'h0;
    logic [15:0] seed = 16'h1891;
    logic [7:0] d_out, a_out, a_oe_n, b_out, b_oe_n, v0, pv [4], ram [4];
    logic       d_oe_n, irq_out, irq_oe_n;
    bus_req_t   bus_req;
    int         err_total = 0;
    int         compares = 0;
    int         n;
    // Pins: driven bits follow the outputs, undriven A bits idle low, undriven B bits invert
    wire logic [7:0] a_pin = a_out & ~a_oe_n;
    wire logic [7:0] b_pin = b_out ^ b_oe_n;
    initial forever #12.5 clock = ~clock;
    bus_master bus_u (.clock(clock), .bus_req(bus_req));
    ram_io_timer dut_u (.clock(clock), .rstn(rstn), .bus_req(bus_req), .data_out(d_out), .data_oe_n(d_oe_n),
        .port_a_lines_in(a_pin), .port_a_lines_out(a_out), .port_a_lines_oe_n(a_oe_n), .port_b_lines_in(b_pin),
        .port_b_lines_out(b_out), .port_b_lines_oe_n(b_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] mix(input logic [7:0] o, input logic [7:0] d, input logic [7:0] e);
        return (o & d) | (e & ~d);
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait for the interrupt wire to be pulled low
    task automatic wait_irq;
        for (n = 0; irq_oe_n !== 1'h0; n++)
        begin
            @(negedge clock);
            if (n > 2200)
            begin
                err_total++;
                print_verdict();
            end
        end
    endtask
    initial
    begin
        repeat (6) @(negedge clock);
        rstn = 1'h1;
        chk("reset dir", 8'hff, a_oe_n);
        chk("reset irq", 8'h01, {7'h00, irq_oe_n});
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            ram[i] = seed[7:0];
            bus_u.xfer(1'h0, 1'h0, 7'(i * 42 + i / 3), seed[7:0]);
            seed = lfsr(seed);
            pv[i] = seed[7:0];
            bus_u.xfer(1'h0, 1'h1, 7'(i), seed[7:0]);
        end
        for (int i = 0; i < 4; i++)
        begin
            bus_u.xfer(1'h1, 1'h0, 7'(i * 42 + i / 3), 8'h00);
            chk("ram", ram[i], d_out);
            bus_u.xfer(1'h1, 1'h1, 7'(i), 8'h00);
            chk("port", i == 0 ? mix(pv[0], pv[1], 8'h00) : i == 2 ? mix(pv[2], pv[3], ~pv[2]) : pv[i], d_out);
        end
        $display("ram and port test done");
        bus_u.xfer(1'h0, 1'h1, 7'h01, 8'hff);
        bus_u.xfer(1'h0, 1'h1, 7'h00, 8'h80);
        for (int k = 0; k < 4; k++)
            bus_u.xfer(1'h1, 1'h1, 7'h05, 8'h00);
        bus_u.xfer(1'h0, 1'h1, 7'h06, 8'h5a);
        bus_u.xfer(1'h0, 1'h1, 7'h00, 8'h00);
        wait_irq();
        bus_u.xfer(1'h1, 1'h1, 7'h05, 8'h00);
        chk("edge flag", 8'h40, d_out);
        bus_u.xfer(1'h1, 1'h1, 7'h05, 8'h00);
        chk("edge clear", 8'h00, d_out);
        bus_u.xfer(1'h0, 1'h1, 7'h07, 8'h00);
        bus_u.xfer(1'h0, 1'h1, 7'h00, 8'h80);
        wait_irq();
        bus_u.xfer(1'h0, 1'h1, 7'h05, 8'h00);
        bus_u.xfer(1'h1, 1'h1, 7'h05, 8'h00);
        chk("edge off", 8'h41, {d_out[7:1], irq_oe_n});
        $display("edge test done");
        for (int c = 0; c < 4; c++)
        begin
            bus_u.xfer(1'h0, 1'h1, 7'h1c | 7'(c), 8'h01);
            wait_irq();
            chk("span", 8'h01, {7'h00, n >= (c == 3 ? 1024 : 1 << (3 * c)) && n <= 2 * (1 << (3 * c + c / 3)) + 4});
            bus_u.xfer(1'h1, 1'h1, 7'h05, 8'h00);
            chk("tmr flag", 8'h80, d_out);
            bus_u.xfer(1'h1, 1'h1, 7'h04, 8'h00);
            v0 = d_out;
            chk("irq off", 8'h01, {7'h00, irq_oe_n});
            bus_u.xfer(1'h1, 1'h1, 7'h04, 8'h00);
            chk("run on", v0 - 8'h02, d_out);
            bus_u.xfer(1'h1, 1'h1, 7'h05, 8'h00);
            chk("tmr clear", 8'h00, d_out);
        end
        bus_u.xfer(1'h0, 1'h1, 7'h14, 8'h01);
        for (int k = 0; k < 5; k++)
            bus_u.xfer(1'h1, 1'h1, 7'h05, 8'h00);
        chk("quiet flag", 8'h81, {d_out[7:1], irq_oe_n});
        $display("timer test done");
        print_verdict();
    end
endmodule
